//--- hw/cpu_throttle_thermal_control.sv
// What this block does
// (RULE_01) Throttle the processor by pulsing stop request low for a share of each period.
// (RULE_02) Manual enable throttles with the manual duty field; period is fixed.
// (RULE_03) Alarm held over two seconds forces throttling with the thermal duty field.
// (RULE_04) Thermal override ends once the alarm input is inactive again.
// (RULE_05) Thermal duty wins over manual duty when both request throttling.
// (RULE_06) Thermal override starts only in the fully working, executing state.
// (RULE_07) Period is 1024 bus clocks; codes 1 to 7 give 12.5 to 87.5 percent.
// (RULE_08) Duty code n holds the stop request for n times 128 bus clocks.
// (RULE_09) Stop time is counted only after the stop grant message arrives.
// (RULE_10) Stop request stays released for a least time before asserting again.
// (RULE_11) Processor I/O system interrupts are raised even while stop is asserted.
// (RULE_12) Host posts stop grant so processor sees cycle end before we do.
// (RULE_13) Processor drains, sends stop grant, resumes when stop request is released.
// (RULE_14) Processor latches interrupt edges while stopped, serves them after release.
// (RULE_15) Polarity low: falling alarm input sets the thermal event flag.
// (RULE_16) Enabled thermal flag raises ACPI interrupt if routed, else system interrupt.
// (RULE_17) Polarity high: alarm returning high raises a further event.
// (RULE_18) Forced bit throttles with the thermal duty field, as a held alarm would.
// (RULE_19) Clearing forced bit stops throttling unless override or manual still requests.
`timescale 1ns/1ps
`default_nettype none

module cpu_throttle_thermal_control
   import throttle_pkg::*;
#(
   parameter longint unsigned THERM_HOLD = THERM_HOLD_PCI
) (
   // Clock and reset
   input  wire  logic                mclk_i,
   input  wire  logic                nrst_i,
   // Register port
   input  wire  reg_req_type         reg_req_i,
   output logic [DATA_W-1:0]         reg_rdata_o,
   // Processor and platform side
   input  wire  logic                thermal_alarm_n_i,
   input  wire  logic                stop_grant_msg_i,
   input  wire  logic                sys_s0c0_i,
   input  wire  logic                io_smi_req_i,
   output logic                      cpu_clock_stop_n_o,
   output logic                      sys_mgmt_irq_n_o,
   output logic                      acpi_irq_o,
   // Interrupt
   output logic                      irq_o
);

   // ----------------------------------------
   // Decode
   // ----------------------------------------
   function automatic logic reg_hit(input logic [ADDR_W-1:0] a,
                                    input logic [ADDR_W-1:0] off);
      return a == off;
   endfunction

   localparam logic [TCNT_W-1:0] HOLD_CNT = TCNT_W'(THERM_HOLD);

   state_type            s_q;
   state_type            s_d;
   logic                 tick;
   logic                 therm_src;
   logic                 req;
   logic [DUTY_W-1:0]    sel_duty;
   logic [PRD_W-1:0]     tgt;
   logic [STS_W-1:0]     sts_clr;
   logic [STS_W-1:0]     ev;
   logic                 start;
   logic                 release_stop;

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      s_d          = s_q;
      ev           = '0;
      sts_clr      = '0;
      start        = 1'b0;
      release_stop = 1'b0;

      // Bus clock rate as an enable, one tick per bus clock
      tick     = (s_q.pdiv == PCI_DIV_LAST);
      s_d.pdiv = tick ? '0 : s_q.pdiv + 3'h1;

      // Register writes
      if (reg_req_i.wr && reg_hit(reg_req_i.addr, OFF_CTRL)) begin
         s_d.ctrl = ctrl_type'(reg_req_i.wdata[CTRL_W-1:0]);
      end
      if (reg_req_i.wr && reg_hit(reg_req_i.addr, OFF_MASK)) begin
         s_d.msk = reg_req_i.wdata[STS_W-1:0];
      end
      if (reg_req_i.wr && reg_hit(reg_req_i.addr, OFF_STATUS)) begin
         sts_clr = reg_req_i.wdata[STS_W-1:0];
      end

      // Alarm edges
      s_d.alarm_n = thermal_alarm_n_i;
      if (s_q.ctrl.thermal_polarity_sel) begin
         ev[STS_THERM] = ~s_q.alarm_n & thermal_alarm_n_i;  // RULE_17
      end else begin
         ev[STS_THERM] = s_q.alarm_n & ~thermal_alarm_n_i;  // RULE_15
      end
      ev[STS_IO_SMI] = io_smi_req_i;  // RULE_11

      // Sustained alarm timer
      if (thermal_alarm_n_i) begin
         s_d.tcnt = '0;
         s_d.ovr  = 1'b0;  // RULE_04
      end else if (tick) begin
         if (s_q.tcnt != HOLD_CNT) begin
            s_d.tcnt = s_q.tcnt + 27'h1;
         end else if (sys_s0c0_i) begin
            s_d.ovr = 1'b1;  // RULE_03 RULE_06
         end
      end
      ev[STS_OVR] = ~s_q.ovr & s_d.ovr;

      // Events win over a clear in the same cycle
      s_d.sts = (s_q.sts & ~sts_clr) | ev;

      // Source selection, thermal first
      therm_src = s_q.ovr | s_q.ctrl.forced_throttle_bit;  // RULE_18 RULE_19
      sel_duty  = therm_src ? s_q.ctrl.thermal_duty_field
                            : s_q.ctrl.manual_duty_field;  // RULE_05 RULE_02
      req       = (therm_src | s_q.ctrl.manual_throttle_enable) && (sel_duty != DUTY_OFF);
      tgt       = PRD_W'({s_q.duty, {DUTY_SH{1'b0}}});  // RULE_07 RULE_08

      // Period and release time counters
      if (tick && s_q.prd != PRD_LAST) begin
         s_d.prd = s_q.prd + 10'h1;
      end
      if (tick && s_q.stop_n && s_q.high != MIN_HIGH) begin
         s_d.high = s_q.high + 3'h1;
      end

      // Throttle sequencer
      case (s_q.fsm)
         ST_IDLE: begin
            start = req && (s_q.high == MIN_HIGH);  // RULE_10
         end
         ST_WAIT_GNT: begin
            if (!req) begin
               release_stop = 1'b1;
               s_d.fsm      = ST_IDLE;
            end else if (stop_grant_msg_i) begin
               s_d.fsm = ST_STOP;  // RULE_09
            end
         end
         ST_STOP: begin
            if (!req) begin
               release_stop = 1'b1;
               s_d.fsm      = ST_IDLE;
            end else if (tick) begin
               if (s_q.act == tgt - 10'h1) begin
                  release_stop = 1'b1;  // RULE_08
                  s_d.fsm      = ST_RUN;
               end else begin
                  s_d.act = s_q.act + 10'h1;
               end
            end
         end
         ST_RUN: begin
            if (!req) begin
               s_d.fsm = ST_IDLE;  // RULE_19
            end else begin
               // Waits for the tick that ends the last slot, so a period is a full 1024 ticks
               start = tick && (s_q.prd == PRD_LAST) && (s_q.high == MIN_HIGH);  // RULE_01 RULE_10
            end
         end
         default: begin
            release_stop = 1'b1;
            s_d.fsm      = ST_IDLE;
         end
      endcase

      if (release_stop) begin
         s_d.stop_n = 1'b1;
      end
      // Duty is latched per period, so a change lands at the next period
      if (start) begin
         s_d.fsm    = ST_WAIT_GNT;
         s_d.stop_n = 1'b0;  // RULE_01
         s_d.duty   = sel_duty;
         s_d.prd    = '0;
         s_d.act    = '0;
         s_d.high   = '0;
      end

      // Interrupt outputs; I/O traps ignore the stop request state
      s_d.acpi  = s_d.sts[STS_THERM] & s_d.ctrl.thermal_event_enable
                & s_d.ctrl.acpi_route_select;  // RULE_16
      s_d.smi_n = ~((s_d.sts[STS_THERM] & s_d.ctrl.thermal_event_enable
                   & ~s_d.ctrl.acpi_route_select) | s_d.sts[STS_IO_SMI]);  // RULE_16 RULE_11
      s_d.irq   = |(s_d.sts & s_d.msk);

      // Read data stands for one cycle only
      s_d.rdata = '0;
      if (reg_req_i.rd) begin
         if (reg_hit(reg_req_i.addr, OFF_CTRL)) begin
            s_d.rdata = DATA_W'(s_q.ctrl);
         end else if (reg_hit(reg_req_i.addr, OFF_STATUS)) begin
            s_d.rdata = DATA_W'(s_q.sts);
         end else if (reg_hit(reg_req_i.addr, OFF_MASK)) begin
            s_d.rdata = DATA_W'(s_q.msk);
         end else if (reg_hit(reg_req_i.addr, OFF_STATE)) begin
            s_d.rdata = DATA_W'({sys_s0c0_i, s_q.alarm_n, req, s_q.ovr, ~s_q.stop_n});
         end
      end
   end

   // ----------------------------------------
   // State register
   // ----------------------------------------
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         s_q <= STATE_RST;
      end else begin
         s_q <= s_d;
      end
   end

   assign reg_rdata_o        = s_q.rdata;
   assign cpu_clock_stop_n_o = s_q.stop_n;
   assign sys_mgmt_irq_n_o   = s_q.smi_n;
   assign acpi_irq_o         = s_q.acpi;
   assign irq_o              = s_q.irq;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!nrst_i);

   sequence stop_begin_s;
      $fell(cpu_clock_stop_n_o);
   endsequence

   sequence grant_wait_s;
      s_q.fsm == ST_WAIT_GNT && req && !stop_grant_msg_i;
   endsequence

   sequence stop_end_s;
      s_q.fsm == ST_STOP && req && tick && s_q.act == tgt - 10'h1;
   endsequence

   stop_begin_a: assert property (stop_begin_s |-> s_q.fsm == ST_WAIT_GNT  // RULE_01
                                  && s_q.act == '0) else $error("stop began outside grant wait");

   min_high_a: assert property (stop_begin_s |-> $past(s_q.high) == MIN_HIGH)  // RULE_10
      else $error("stop request reasserted too early");

   grant_hold_a: assert property (grant_wait_s |=> s_q.act == '0  // RULE_09
                                  && !cpu_clock_stop_n_o) else $error("counted before grant");

   duty_len_a: assert property (stop_end_s |=> cpu_clock_stop_n_o  // RULE_08
                                && s_q.fsm == ST_RUN) else $error("stop time wrong length");

   therm_prio_a: assert property (stop_begin_s and $past(therm_src)  // RULE_05
                                  |-> s_q.duty == $past(s_q.ctrl.thermal_duty_field))
      else $error("thermal duty not applied");

   manual_duty_a: assert property (stop_begin_s and !$past(therm_src)  // RULE_02
                                   |-> s_q.duty == $past(s_q.ctrl.manual_duty_field))
      else $error("manual duty not applied");

   no_req_a: assert property (s_q.fsm != ST_IDLE && !req |=> cpu_clock_stop_n_o  // RULE_04
                              ##1 cpu_clock_stop_n_o) else $error("throttle kept without request");

   ovr_s0_a: assert property (!sys_s0c0_i && !s_q.ovr |=> !s_q.ovr)  // RULE_06
      else $error("override started outside working state");

   fall_flag_a: assert property (!s_q.ctrl.thermal_polarity_sel && s_q.alarm_n  // RULE_15
                                 && !thermal_alarm_n_i |=> s_q.sts[STS_THERM])
      else $error("falling alarm did not set flag");

   rise_flag_a: assert property (s_q.ctrl.thermal_polarity_sel && !s_q.alarm_n  // RULE_17
                                 && thermal_alarm_n_i |=> s_q.sts[STS_THERM])
      else $error("rising alarm did not set flag");

   route_sel_a: assert property (s_q.sts[STS_THERM] && s_q.ctrl.thermal_event_enable  // RULE_16
                                 |-> acpi_irq_o == s_q.ctrl.acpi_route_select
                                 && sys_mgmt_irq_n_o == (s_q.ctrl.acpi_route_select
                                                         && !s_q.sts[STS_IO_SMI]))
      else $error("thermal interrupt misrouted");

   io_smi_a: assert property (io_smi_req_i |=> !sys_mgmt_irq_n_o)  // RULE_11
      else $error("I/O trap interrupt missing");

endmodule

`default_nettype wire

//--- hw/throttle_pkg.sv
package throttle_pkg;

   // ----------------------------------------
   // Clock and time base
   // ----------------------------------------
   localparam int unsigned CLK_PERIOD_NS = 4;
   localparam int unsigned PCI_PERIOD_NS = 30;
   // Rounded up, so the throttle clock never runs faster than the bus clock
   localparam int unsigned PCI_DIV       = (PCI_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned PDIV_W        = 3;
   localparam logic [PDIV_W-1:0] PCI_DIV_LAST = PDIV_W'(PCI_DIV - 1);

   // Sustained alarm time before thermal override
   localparam longint unsigned THERM_HOLD_S   = 2;
   localparam longint unsigned THERM_HOLD_NS  = THERM_HOLD_S * 1000000000;
   localparam longint unsigned THERM_HOLD_PCI =
      (THERM_HOLD_NS + PCI_PERIOD_NS - 1) / PCI_PERIOD_NS;
   localparam int unsigned TCNT_W = 27;

   // Throttle period and duty step, in throttle ticks
   localparam int unsigned PRD_W                = 10;
   localparam logic [PRD_W-1:0] PRD_LAST        = 10'h3ff;
   localparam int unsigned DUTY_W               = 3;
   localparam int unsigned DUTY_SH              = 7;
   localparam logic [DUTY_W-1:0] DUTY_OFF       = 3'h0;
   // Least time the stop request stays released before it may assert again
   localparam int unsigned HIGH_W               = 3;
   localparam logic [HIGH_W-1:0] MIN_HIGH       = 3'h4;

   // ----------------------------------------
   // Register map
   // ----------------------------------------
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 32;
   localparam logic [ADDR_W-1:0] OFF_CTRL   = 8'h00;
   localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h04;
   localparam logic [ADDR_W-1:0] OFF_MASK   = 8'h08;
   localparam logic [ADDR_W-1:0] OFF_STATE  = 8'h0c;

   localparam int unsigned STS_W      = 3;
   localparam int unsigned STS_THERM  = 0;
   localparam int unsigned STS_IO_SMI = 1;
   localparam int unsigned STS_OVR    = 2;

   typedef struct packed {
      logic                acpi_route_select;
      logic                thermal_event_enable;
      logic                thermal_polarity_sel;
      logic                forced_throttle_bit;
      logic [DUTY_W-1:0]   thermal_duty_field;
      logic                manual_throttle_enable;
      logic [DUTY_W-1:0]   manual_duty_field;
   } ctrl_type;
   localparam int unsigned CTRL_W = $bits(ctrl_type);

   typedef struct packed {
      logic [ADDR_W-1:0]   addr;
      logic [DATA_W-1:0]   wdata;
      logic                wr;
      logic                rd;
   } reg_req_type;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_WAIT_GNT,
      ST_STOP,
      ST_RUN
   } fsm_type;

   typedef struct packed {
      ctrl_type            ctrl;
      logic [STS_W-1:0]    sts;
      logic [STS_W-1:0]    msk;
      logic                ovr;
      logic [TCNT_W-1:0]   tcnt;
      logic [PDIV_W-1:0]   pdiv;
      fsm_type             fsm;
      logic [PRD_W-1:0]    prd;
      logic [PRD_W-1:0]    act;
      logic [HIGH_W-1:0]   high;
      logic [DUTY_W-1:0]   duty;
      logic                alarm_n;
      logic                stop_n;
      logic                smi_n;
      logic                acpi;
      logic                irq;
      logic [DATA_W-1:0]   rdata;
   } state_type;

   localparam state_type STATE_RST = '{
      ctrl: '0, sts: '0, msk: '0, ovr: 1'b0, tcnt: '0, pdiv: '0, fsm: ST_IDLE,
      prd: '0, act: '0, high: '0, duty: '0, alarm_n: 1'b1, stop_n: 1'b1,
      smi_n: 1'b1, acpi: 1'b0, irq: 1'b0, rdata: '0};

endpackage

//--- tb/cpu_stub.sv
`timescale 1ns/1ps
`default_nettype none

module cpu_stub (
   // Clock and reset
   input  wire logic       mclk_i,
   input  wire logic       nrst_i,
   // Stop request and grant message
   input  wire logic       stop_n_i,
   input  wire logic [7:0] delay_i,
   output logic            grant_o,
   // System interrupt seen by the processor
   input  wire logic       smi_n_i,
   output logic            pend_o
);
   // --------------------------
   // Processor stand-in
   // --------------------------
   logic [8:0] cnt_q;
   logic       prev_q;
   logic       smi_prev_q;

   // Interrupt edges latched while stopped, served once stop is released
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         smi_prev_q <= 1'b1;
         pend_o     <= 1'b0;
      end else begin
         smi_prev_q <= smi_n_i;
         if (stop_n_i) begin
            pend_o <= 1'b0;
         end else if (smi_prev_q && !smi_n_i) begin
            pend_o <= 1'b1;
         end
      end
   end

   // Drain time is delay_i plus one, so grant never beats the cycle end
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         cnt_q   <= 9'h000;
         prev_q  <= 1'b1;
         grant_o <= 1'b0;
      end else begin
         prev_q  <= stop_n_i;
         grant_o <= 1'b0;
         if (prev_q && !stop_n_i) begin
            cnt_q <= {1'b0, delay_i} + 9'h001;
         end else if (cnt_q != 9'h000) begin
            cnt_q   <= cnt_q - 9'h001;
            grant_o <= (cnt_q == 9'h001) && !stop_n_i;
         end
      end
   end
endmodule

`default_nettype wire

//--- tb/cpu_throttle_thermal_control_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module cpu_throttle_thermal_control_tb_top
   import throttle_pkg::*;
;
   logic        mclk_i;
   logic        nrst_i;
   reg_req_type req;
   logic [31:0] rdata;
   logic [31:0] rdat;
   logic        alarm_n;
   logic        s0c0;
   logic        io_smi;
   logic        grant;
   logic        stop_n;
   logic        smi_n;
   logic        acpi;
   logic        irq;
   logic        pend;
   logic [7:0]  dly;
   logic [7:0]  rnd;
   logic [2:0]  n;
   int          bad_count;
   int          check_count;

   cpu_throttle_thermal_control #(.THERM_HOLD(20)) dut (
      .mclk_i             (mclk_i),
      .nrst_i             (nrst_i),
      .reg_req_i          (req),
      .reg_rdata_o        (rdata),
      .thermal_alarm_n_i  (alarm_n),
      .stop_grant_msg_i   (grant),
      .sys_s0c0_i         (s0c0),
      .io_smi_req_i       (io_smi),
      .cpu_clock_stop_n_o (stop_n),
      .sys_mgmt_irq_n_o   (smi_n),
      .acpi_irq_o         (acpi),
      .irq_o              (irq)
   );

   cpu_stub cpu (
      .mclk_i   (mclk_i),
      .nrst_i   (nrst_i),
      .stop_n_i (stop_n),
      .delay_i  (dly),
      .grant_o  (grant),
      .smi_n_i  (smi_n),
      .pend_o   (pend)
   );

   // --------------------------
   // Helpers
   // --------------------------
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction

   function automatic logic [31:0] low_cycles(input logic [2:0] c);
      return 32'(c) * 32'd128 * PCI_DIV;
   endfunction

   task automatic stop_test();
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input int tol = 0);
      logic [31:0] d;
      check_count++;
      d = (got > exp) ? got - exp : exp - got;
      if (got !== exp && (tol == 0 || ^got === 1'bx || d > tol)) begin
         bad_count++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic chk1(input logic got, input logic exp);
      chk({31'h0, got}, {31'h0, exp});
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk_i);
      req.addr  <= a;
      req.wdata <= d;
      req.wr    <= 1'b1;
      @(posedge mclk_i);
      req.wr    <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a);
      @(posedge mclk_i);
      req.addr <= a;
      req.rd   <= 1'b1;
      @(posedge mclk_i);
      req.rd   <= 1'b0;
      #1 rdat = rdata;
   endtask

   task automatic io_pulse();
      @(posedge mclk_i);
      io_smi <= 1'b1;
      @(posedge mclk_i);
      io_smi <= 1'b0;
      @(negedge mclk_i);
   endtask

   // Bounded wait for a stop level; a hang ends the run
   task automatic wait_stop(input logic lvl, output int t);
      t = 0;
      while (stop_n !== lvl) begin
         @(negedge mclk_i);
         t++;
         if (t > 20000) begin
            bad_count++;
            stop_test();
         end
      end
   endtask

   // Measures one whole period; low time counted from the grant
   task automatic period(input logic [2:0] c);
      int t;
      int g;
      int h;
      wait_stop(1'b1, t);
      wait_stop(1'b0, t);
      t = 0;
      g = 0;
      while (stop_n === 1'b0 && t < 20000) begin
         @(negedge mclk_i);
         t++;
         if (g > 0 || grant === 1'b1) g++;
      end
      wait_stop(1'b0, h);
      chk(32'(g), low_cycles(c), 16);
      chk(32'(t + h), 32'd1024 * PCI_DIV, 2);
      chk1(h >= MIN_HIGH * PCI_DIV, 1'b1);
   endtask

   // --------------------------
   // Sequence
   // --------------------------
   initial begin
      mclk_i = 1'b0;
      forever #2 mclk_i = ~mclk_i;
   end

   initial begin
      req = '0;
      alarm_n = 1'b1;
      s0c0 = 1'b1;
      io_smi = 1'b0;
      dly = 8'h00;
      rnd = 8'h53;
      bad_count = 0;
      check_count = 0;
      nrst_i = 1'b0;
      repeat (10) @(posedge mclk_i);
      nrst_i <= 1'b1;
      @(negedge mclk_i);
      chk({28'h0, stop_n, smi_n, acpi, irq}, 32'hc);
      rnd = lfsr(rnd);
      wr(OFF_CTRL, {21'h1fffff, 3'h5, rnd});
      rd(OFF_CTRL);
      chk(rdat, {21'h0, 3'h5, rnd});
      wr(OFF_MASK, 32'hffffffff);
      rd(OFF_MASK);
      chk(rdat, 32'h7);
      rd(8'h10);
      chk(rdat, 32'h0);
      // Manual throttling, top code then a random code with slow grant
      wr(OFF_CTRL, 32'h0f);
      period(3'h7);
      rnd = lfsr(rnd);
      dly <= rnd;
      rnd = lfsr(rnd);
      n = 3'(rnd % 8'd7) + 3'h1;
      wr(OFF_CTRL, {28'h0, 1'b1, n});
      period(n);
      // Thermal alarm, held first outside the working state
      dly <= 8'h03;
      wr(OFF_STATUS, 32'h7);
      wr(OFF_CTRL, 32'h62d);
      s0c0 <= 1'b0;
      alarm_n <= 1'b0;
      repeat (3) @(negedge mclk_i);
      chk1(acpi, 1'b1);
      repeat (300) @(negedge mclk_i);
      rd(OFF_STATE);
      chk1(rdat[1], 1'b0);
      s0c0 <= 1'b1;
      repeat (300) @(negedge mclk_i);
      rd(OFF_STATE);
      chk1(rdat[1], 1'b1);
      period(3'h2);
      wr(OFF_STATUS, 32'h7);
      wr(OFF_CTRL, 32'h320);
      alarm_n <= 1'b1;
      repeat (3) @(negedge mclk_i);
      chk1(smi_n, 1'b0);
      chk1(stop_n, 1'b1);
      // Forced throttling, I/O interrupt while stopped, mask
      wr(OFF_STATUS, 32'h7);
      wr(OFF_MASK, 32'h2);
      wr(OFF_CTRL, 32'hb0);
      period(3'h3);
      io_pulse();
      chk({29'h0, stop_n, smi_n, irq}, 32'h1);
      @(negedge mclk_i);
      chk1(pend, 1'b1);
      wr(OFF_STATUS, 32'h2);
      @(negedge mclk_i);
      chk({30'h0, smi_n, irq}, 32'h2);
      wr(OFF_MASK, 32'h0);
      io_pulse();
      chk({30'h0, smi_n, irq}, 32'h0);
      wr(OFF_STATUS, 32'h2);
      wr(OFF_CTRL, 32'h30);
      repeat (3) @(negedge mclk_i);
      chk1(stop_n, 1'b1);
      @(negedge mclk_i);
      chk1(pend, 1'b0);
      stop_test();
   end
endmodule

`default_nettype wire
